// ---- design/lsb_sync_ctrl.sv ----
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Bit 11 clear lets break compare interrupt
// - Bit 10 set masks break timer error interrupt
// - Test mode routes transceiver through test pins
// - Test mode clear links transceiver to UART
// - In LIN mode gate bit holds UART receive high until the sync field is done
// - Gate clear passes UART receive data through
// - Bus read mode: rising edge sets break status
// - Break timer runs falling to rising edge
// - Break timer interrupts on compare and overflow
// - Bus write mode: no rising edge break events
// - Write mode break timer stops on rising edge
// - Bit 7 stops sync timer on counted rising edge
// - Bit 12 polarity flips between bus modes
// - Mode bit one selects battery sensor bus
// - Enabled sync compare sets status bit 3
module lsb_sync_ctrl (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire lsb_pkg::lsb_reg_req_t reg_req,
    output logic              [31:0] reg_rdata,
    input  wire lsb_pkg::lsb_pin_in_t pin_in,
    input  wire logic                uart_txd,
    output logic                     uart_rxd,
    output logic                     xcvr_txd,
    output logic                     test_rxd,
    output logic                     irq
);
    localparam int TW = lsb_pkg::LSB_TMR_W;

    lsb_pkg::lsb_state_t st;
    lsb_pkg::lsb_state_t next_st;

    logic [1:0]    pins_sync;
    logic          bus_rx;
    logic          test_tx;
    logic          rise;
    logic          fall;
    logic [TW-1:0] brk_count;
    logic          brk_run;
    logic          brk_match;
    logic          brk_ovf;
    logic [TW-1:0] sync_count;
    logic          sync_run;
    logic          sync_match;
    logic          sync_start;
    logic          sync_stop;
    logic          sync_done;
    logic          stop_edge;
    logic          rise_ie;
    logic          break_evt;
    logic [lsb_pkg::LSB_ST_W-1:0] st_set;
    logic [lsb_pkg::LSB_ST_W-1:0] st_clr;
    logic [lsb_pkg::LSB_ST_W-1:0] irq_en;

    lsb_sync2 #(
        .W (lsb_pkg::LSB_SYNC_STAGES)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in ({pin_in.xcvr_rxd, pin_in.test_txd}),
        .sync_out (pins_sync)
    );

    assign bus_rx  = pins_sync[1];
    assign test_tx = pins_sync[0];
    assign rise    = bus_rx & ~st.rx_prev;
    assign fall    = ~bus_rx & st.rx_prev;

    // Break timer: starts on falling, stops on rising, in every mode
    lsb_timer #(
        .W (TW)
    ) u_brk_tmr (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (fall),
        .stop    (rise),
        .cmp     (st.brk_cmp),
        .count   (brk_count),
        .running (brk_run),
        .match   (brk_match),
        .ovf     (brk_ovf)
    );

    // Sync timer: bus mode times each pulse, LIN mode times the sync field
    always_comb begin
        stop_edge = st.ctrl[lsb_pkg::LSB_CTRL_STOP_RISE] ? rise : fall;
        sync_done = (st.phase == lsb_pkg::LSB_IN_SYNC) && stop_edge
                    && ((st.edge_cnt + 4'h1) == st.edge_sel);
        if (st.mode_bsd) begin
            sync_start = fall;
            sync_stop  = rise;
        end else begin
            sync_start = (st.phase == lsb_pkg::LSB_IN_BREAK) && rise;
            sync_stop  = sync_done;
        end
    end

    lsb_timer #(
        .W (TW)
    ) u_sync_tmr (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (sync_start),
        .stop    (sync_stop),
        .cmp     (st.sync_cmp),
        .count   (sync_count),
        .running (sync_run),
        .match   (sync_match),
        .ovf     ()
    );

    always_comb begin
        // Same bit, opposite sense in the two modes
        rise_ie = st.mode_bsd ? ~st.ctrl[lsb_pkg::LSB_CTRL_RISE_IE]
                              : st.ctrl[lsb_pkg::LSB_CTRL_RISE_IE];
        if (st.mode_bsd) begin
            break_evt = rise && st.ctrl[lsb_pkg::LSB_CTRL_GATE];
        end else begin
            break_evt = rise && (st.phase == lsb_pkg::LSB_IN_BREAK);
        end
        st_set = '0;
        st_set[lsb_pkg::LSB_ST_BREAK]    = break_evt;
        st_set[lsb_pkg::LSB_ST_BRK_CMP]  = brk_match;
        st_set[lsb_pkg::LSB_ST_BRK_OVF]  = brk_ovf;
        st_set[lsb_pkg::LSB_ST_SYNC_CMP] = sync_match && st.cmp_en;
        st_set[lsb_pkg::LSB_ST_SYNC_END] = sync_done;
        st_clr = '0;
        if (reg_req.wr && (reg_req.addr == lsb_pkg::LSB_OFF_STATUS)) begin
            st_clr = reg_req.wdata[lsb_pkg::LSB_ST_W-1:0];
        end
        // Masks act on the request line only; the flags still collect, except sync compare, which cmp_en also gates
        irq_en = '0;
        irq_en[lsb_pkg::LSB_ST_BREAK]    = rise_ie;
        irq_en[lsb_pkg::LSB_ST_BRK_CMP]  = ~st.ctrl[lsb_pkg::LSB_CTRL_CMP_DIS];
        irq_en[lsb_pkg::LSB_ST_BRK_OVF]  = ~st.ctrl[lsb_pkg::LSB_CTRL_ERR_DIS];
        irq_en[lsb_pkg::LSB_ST_SYNC_CMP] = st.cmp_en;
        irq_en[lsb_pkg::LSB_ST_SYNC_END] = 1'b0;
    end

    always_comb begin
        next_st         = st;
        next_st.rx_prev = bus_rx;
        next_st.rdata   = 32'h0000_0000;
        // Set wins over a clear in the same cycle
        next_st.status  = (st.status & ~st_clr) | st_set;

        // LIN frame tracking; a long low anywhere starts a new frame
        if (brk_match && !bus_rx) begin
            next_st.phase = lsb_pkg::LSB_IN_BREAK;
        end else begin
            case (st.phase)
                lsb_pkg::LSB_WAIT_BREAK: begin
                    next_st.phase = lsb_pkg::LSB_WAIT_BREAK;
                end
                lsb_pkg::LSB_IN_BREAK: begin
                    if (rise) begin
                        next_st.phase    = lsb_pkg::LSB_IN_SYNC;
                        next_st.edge_cnt = 4'h0;
                    end
                end
                lsb_pkg::LSB_IN_SYNC: begin
                    if (sync_done) begin
                        next_st.phase = lsb_pkg::LSB_IN_DATA;
                    end else if (stop_edge) begin
                        next_st.edge_cnt = st.edge_cnt + 4'h1;
                    end
                end
                lsb_pkg::LSB_IN_DATA: begin
                    next_st.phase = lsb_pkg::LSB_IN_DATA;
                end
                default: begin
                    next_st.phase = lsb_pkg::LSB_WAIT_BREAK;
                end
            endcase
        end

        // Transceiver and UART routing
        if (st.ctrl[lsb_pkg::LSB_CTRL_TEST]) begin
            next_st.xcvr_txd = test_tx;
            next_st.test_rxd = bus_rx;
            next_st.uart_rxd = 1'b1;
        end else begin
            next_st.xcvr_txd = uart_txd;
            next_st.test_rxd = 1'b1;
            // Keeps break and sync bytes out of the UART receive buffer
            if (!st.mode_bsd && st.ctrl[lsb_pkg::LSB_CTRL_GATE]
                && (st.phase != lsb_pkg::LSB_IN_DATA)) begin
                next_st.uart_rxd = 1'b1;
            end else begin
                next_st.uart_rxd = bus_rx;
            end
        end

        // Register writes
        if (reg_req.wr) begin
            if (reg_req.addr == lsb_pkg::LSB_OFF_CTRL) begin
                next_st.ctrl = reg_req.wdata[lsb_pkg::LSB_CTRL_W-1:0];
                next_st.ctrl[lsb_pkg::LSB_CTRL_STOP_RISE-1:0] = '0;
            end else if (reg_req.addr == lsb_pkg::LSB_OFF_BRK_TMR) begin
                next_st.brk_cmp = reg_req.wdata[TW-1:0];
            end else if (reg_req.addr == lsb_pkg::LSB_OFF_SYNC_CMP) begin
                next_st.sync_cmp = reg_req.wdata[TW-1:0];
            end else if (reg_req.addr == lsb_pkg::LSB_OFF_CTRL2) begin
                next_st.mode_bsd = reg_req.wdata[lsb_pkg::LSB_CTRL2_MODE_BSD];
                next_st.cmp_en   = reg_req.wdata[lsb_pkg::LSB_CTRL2_CMP_EN];
                next_st.edge_sel = reg_req.wdata[lsb_pkg::LSB_CTRL2_EDGE_HI:lsb_pkg::LSB_CTRL2_EDGE_LO];
            end
        end

        // Register reads: data only in the cycle after the strobe
        if (reg_req.rd) begin
            if (reg_req.addr == lsb_pkg::LSB_OFF_CTRL) begin
                next_st.rdata = {19'h00000, st.ctrl};
            end else if (reg_req.addr == lsb_pkg::LSB_OFF_STATUS) begin
                next_st.rdata = {27'h0000000, st.status};
            end else if (reg_req.addr == lsb_pkg::LSB_OFF_BRK_TMR) begin
                next_st.rdata = {16'h0000, brk_count};
            end else if (reg_req.addr == lsb_pkg::LSB_OFF_SYNC_TMR) begin
                next_st.rdata = {16'h0000, sync_count};
            end else if (reg_req.addr == lsb_pkg::LSB_OFF_SYNC_CMP) begin
                next_st.rdata = {16'h0000, st.sync_cmp};
            end else if (reg_req.addr == lsb_pkg::LSB_OFF_CTRL2) begin
                next_st.rdata = {24'h000000, st.edge_sel, 2'h0, st.cmp_en, st.mode_bsd};
            end else begin
                next_st.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st          <= '0;
            st.ctrl     <= lsb_pkg::LSB_CTRL_RST;
            st.brk_cmp  <= lsb_pkg::LSB_CMP_RST;
            st.sync_cmp <= lsb_pkg::LSB_CMP_RST;
            st.edge_sel <= lsb_pkg::LSB_EDGE_RST;
            st.phase    <= lsb_pkg::LSB_WAIT_BREAK;
            st.rx_prev  <= 1'b1;
            st.xcvr_txd <= 1'b1;
            st.test_rxd <= 1'b1;
            st.uart_rxd <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign uart_rxd  = st.uart_rxd;
    assign xcvr_txd  = st.xcvr_txd;
    assign test_rxd  = st.test_rxd;
    assign irq       = |(st.status & irq_en);

    default clocking lsb_cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_break_low;
        brk_match && !bus_rx;
    endsequence

    sequence s_gate_on;
        !st.mode_bsd && st.ctrl[lsb_pkg::LSB_CTRL_GATE] && !st.ctrl[lsb_pkg::LSB_CTRL_TEST];
    endsequence

    brk_cmp_mask_a: assert property (
        st.status[lsb_pkg::LSB_ST_BRK_CMP] && !st.ctrl[lsb_pkg::LSB_CTRL_CMP_DIS] |-> irq)
        else $error("break compare flag not raising irq");

    brk_err_mask_a: assert property (
        st.status[lsb_pkg::LSB_ST_BRK_OVF] && st.ctrl[lsb_pkg::LSB_CTRL_ERR_DIS]
        && st.ctrl[lsb_pkg::LSB_CTRL_CMP_DIS] && !st.status[lsb_pkg::LSB_ST_BREAK]
        && !st.status[lsb_pkg::LSB_ST_SYNC_CMP] |-> !irq)
        else $error("masked break error still raises irq");

    test_route_a: assert property (
        st.ctrl[lsb_pkg::LSB_CTRL_TEST] && $stable(st.ctrl) |=> (xcvr_txd == $past(test_tx)))
        else $error("test pin not routed to transceiver");

    uart_route_a: assert property (
        !st.ctrl[lsb_pkg::LSB_CTRL_TEST] && $stable(st.ctrl) |=> (xcvr_txd == $past(uart_txd)))
        else $error("uart transmit not routed to transceiver");

    rx_gate_a: assert property (
        s_gate_on and (st.phase != lsb_pkg::LSB_IN_DATA) |=> uart_rxd)
        else $error("uart receive not held high before sync");

    rx_pass_a: assert property (
        !st.ctrl[lsb_pkg::LSB_CTRL_TEST] && !st.ctrl[lsb_pkg::LSB_CTRL_GATE] && !st.mode_bsd
        |=> (uart_rxd == $past(bus_rx)))
        else $error("uart receive not passed through");

    bsd_read_brk_a: assert property (
        st.mode_bsd && st.ctrl[lsb_pkg::LSB_CTRL_GATE] && rise |=> st.status[lsb_pkg::LSB_ST_BREAK])
        else $error("rising edge missed in bus read mode");

    bsd_write_quiet_a: assert property (
        st.mode_bsd && !st.ctrl[lsb_pkg::LSB_CTRL_GATE] && !st.status[lsb_pkg::LSB_ST_BREAK]
        |=> !st.status[lsb_pkg::LSB_ST_BREAK])
        else $error("break event raised in bus write mode");

    brk_timer_a: assert property (
        fall ##1 (!rise) [*3] |-> (brk_count == 16'h0002) || !brk_run)
        else $error("break timer not counting from falling edge");

    brk_stop_a: assert property (
        rise ##1 !fall |-> !brk_run ##1 $stable(brk_count))
        else $error("break timer not stopped by rising edge");

    brk_ovf_a: assert property (
        brk_ovf |=> st.status[lsb_pkg::LSB_ST_BRK_OVF])
        else $error("overflow not flagged");

    brk_match_a: assert property (
        brk_match |=> st.status[lsb_pkg::LSB_ST_BRK_CMP])
        else $error("break compare not flagged");

    test_hold_a: assert property (
        st.ctrl[lsb_pkg::LSB_CTRL_TEST] |=> uart_rxd && (test_rxd == $past(bus_rx)))
        else $error("test mode receive routing wrong");

    test_idle_a: assert property (
        !st.ctrl[lsb_pkg::LSB_CTRL_TEST] |=> test_rxd)
        else $error("test pin output not idle outside test mode");

    rdata_idle_a: assert property (
        !reg_req.rd |=> (reg_rdata == 32'h0000_0000))
        else $error("read data standing without a read");

    sync_stop_a: assert property (
        sync_done && !st.mode_bsd |=> !sync_run && (st.phase == lsb_pkg::LSB_IN_DATA))
        else $error("sync timer not stopped on counted edge");

    rise_pol_a: assert property (
        st.mode_bsd && st.ctrl[lsb_pkg::LSB_CTRL_RISE_IE]
        && (st.status == (5'h1 << lsb_pkg::LSB_ST_BREAK)) |-> !irq)
        else $error("rising edge irq not disabled in bus mode");

    rise_lin_a: assert property (
        !st.mode_bsd && st.ctrl[lsb_pkg::LSB_CTRL_RISE_IE] && st.status[lsb_pkg::LSB_ST_BREAK] |-> irq)
        else $error("rising edge irq not enabled in lin mode");

    sync_cmp_a: assert property (
        sync_match && st.cmp_en |=> st.status[lsb_pkg::LSB_ST_SYNC_CMP] && (irq || !st.cmp_en))
        else $error("sync compare not flagged");

    new_frame_a: assert property (
        s_break_low |=> (st.phase == lsb_pkg::LSB_IN_BREAK))
        else $error("long low did not start a frame");

endmodule

// ---- design/lsb_pkg.sv ----
package lsb_pkg;

    // Register byte addresses
    localparam logic [7:0] LSB_OFF_CTRL     = 8'h00;
    localparam logic [7:0] LSB_OFF_STATUS   = 8'h04;
    localparam logic [7:0] LSB_OFF_BRK_TMR  = 8'h08;
    localparam logic [7:0] LSB_OFF_SYNC_TMR = 8'h0c;
    localparam logic [7:0] LSB_OFF_SYNC_CMP = 8'h10;
    localparam logic [7:0] LSB_OFF_CTRL2    = 8'h14;

    // Control register field positions
    localparam int LSB_CTRL_STOP_RISE = 7;
    localparam int LSB_CTRL_GATE      = 8;
    localparam int LSB_CTRL_TEST      = 9;
    localparam int LSB_CTRL_ERR_DIS   = 10;
    localparam int LSB_CTRL_CMP_DIS   = 11;
    localparam int LSB_CTRL_RISE_IE   = 12;
    localparam int LSB_CTRL_W         = 13;

    // Second sync control register field positions
    localparam int LSB_CTRL2_MODE_BSD = 0;
    localparam int LSB_CTRL2_CMP_EN   = 1;
    localparam int LSB_CTRL2_EDGE_LO  = 4;
    localparam int LSB_CTRL2_EDGE_HI  = 7;

    // Status register bit positions
    localparam int LSB_ST_BREAK    = 0;
    localparam int LSB_ST_BRK_CMP  = 1;
    localparam int LSB_ST_BRK_OVF  = 2;
    localparam int LSB_ST_SYNC_CMP = 3;
    localparam int LSB_ST_SYNC_END = 4;
    localparam int LSB_ST_W        = 5;

    // Widths and values after reset
    localparam int                     LSB_TMR_W      = 16;
    localparam logic [LSB_CTRL_W-1:0]  LSB_CTRL_RST   = 13'h0000;
    localparam logic [LSB_TMR_W-1:0]   LSB_CMP_RST    = 16'hffff;
    localparam logic [3:0]             LSB_EDGE_RST   = 4'h5;
    localparam int                     LSB_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        LSB_WAIT_BREAK = 2'b00,
        LSB_IN_BREAK   = 2'b01,
        LSB_IN_SYNC    = 2'b11,
        LSB_IN_DATA    = 2'b10
    } lsb_phase_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } lsb_reg_req_t;

    typedef struct packed {
        logic xcvr_rxd;
        logic test_txd;
    } lsb_pin_in_t;

    typedef struct packed {
        logic [LSB_CTRL_W-1:0] ctrl;
        logic                  mode_bsd;
        logic                  cmp_en;
        logic [3:0]            edge_sel;
        logic [LSB_ST_W-1:0]   status;
        logic [LSB_TMR_W-1:0]  brk_cmp;
        logic [LSB_TMR_W-1:0]  sync_cmp;
        lsb_phase_t            phase;
        logic [3:0]            edge_cnt;
        logic                  rx_prev;
        logic                  xcvr_txd;
        logic                  test_rxd;
        logic                  uart_rxd;
        logic [31:0]           rdata;
    } lsb_state_t;

endpackage

// ---- design/lsb_sync2.sv ----
`timescale 1ns/1ps
module lsb_sync2 #(
    parameter int W = 2
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } lsb_sync_st_t;

    lsb_sync_st_t st;
    lsb_sync_st_t next_st;

    // Idle bus is recessive high, so reset to ones
    always_comb begin
        next_st.meta   = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule

// ---- design/lsb_timer.sv ----
`timescale 1ns/1ps
module lsb_timer #(
    parameter int W = lsb_pkg::LSB_TMR_W
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] cmp,
    output logic      [W-1:0] count,
    output logic              running,
    output logic              match,
    output logic              ovf
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         run;
        logic         match;
        logic         ovf;
    } lsb_tmr_st_t;

    lsb_tmr_st_t st;
    lsb_tmr_st_t next_st;

    always_comb begin
        next_st       = st;
        next_st.match = 1'b0;
        next_st.ovf   = 1'b0;
        if (start) begin
            next_st.cnt = '0;
            next_st.run = 1'b1;
        end else if (stop) begin
            next_st.run = 1'b0;
        end else if (st.run) begin
            // Saturate at full scale: overflow is reported once, count freezes
            if (&st.cnt) begin
                next_st.run = 1'b0;
                next_st.ovf = 1'b1;
            end else begin
                next_st.cnt   = st.cnt + 1'b1;
                next_st.match = ((st.cnt + 1'b1) == cmp);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count   = st.cnt;
    assign running = st.run;
    assign match   = st.match;
    assign ovf     = st.ovf;
endmodule

// ---- tb/lsb_bus_node.sv ----
`timescale 1ns/1ps
module lsb_bus_node (
    input  wire logic ref_clk,
    output logic      bus
);
    // Pulled up by the master node: a released line is recessive high
    initial bus = 1'b1;

    task automatic hold(input logic lvl, input int n);
        bus <= lvl;
        repeat (n) @(posedge ref_clk);
    endtask
endmodule

// ---- tb/lin_sync_break_control_test.sv ----
`timescale 1ns/1ps
module lin_sync_break_control_test;
    localparam logic [7:0] A_CTRL = lsb_pkg::LSB_OFF_CTRL;
    localparam logic [7:0] A_ST   = lsb_pkg::LSB_OFF_STATUS;
    localparam logic [7:0] A_BRK  = lsb_pkg::LSB_OFF_BRK_TMR;
    localparam logic [7:0] A_SYN  = lsb_pkg::LSB_OFF_SYNC_TMR;
    localparam logic [7:0] A_CMP  = lsb_pkg::LSB_OFF_SYNC_CMP;
    localparam logic [7:0] A_C2   = lsb_pkg::LSB_OFF_CTRL2;
    logic                  ref_clk;
    logic                  resetn;
    lsb_pkg::lsb_reg_req_t req;
    logic [31:0]           reg_rdata;
    logic                  uart_txd;
    logic                  test_pin;
    logic                  uart_rxd;
    logic                  xcvr_txd;
    logic                  test_rxd;
    logic                  irq;
    logic                  bus;
    logic [31:0]           d;
    logic [31:0]           d2;
    logic                  v;
    int                    errors;
    int                    samples_checked;
    int                    seed;
    int                    n;

    lsb_bus_node node (.ref_clk(ref_clk), .bus(bus));

    lsb_sync_ctrl dut (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .reg_req  (req),
        .reg_rdata(reg_rdata),
        .pin_in   ({bus, test_pin}),
        .uart_txd (uart_txd),
        .uart_rxd (uart_rxd),
        .xcvr_txd (xcvr_txd),
        .test_rxd (test_rxd),
        .irq      (irq)
    );

    always #2.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] ctrl2_val(input logic battery_sensor_bus, input logic cmp, input logic [3:0] edge_no);
        return {24'h000000, edge_no, 2'b00, cmp, battery_sensor_bus};
    endfunction

    task automatic complete_run();
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 r = reg_rdata;
    endtask

    // Low pulse, then enough idle for the synchroniser and status to settle
    task automatic pulse(input int len);
        node.hold(1'b0, len);
        node.hold(1'b1, 8);
    endtask

    initial begin
        repeat (95000) @(posedge ref_clk);
        errors++;
        complete_run();
    end

    initial begin
        seed = 32'hb431;
        errors = 0;
        samples_checked = 0;
        ref_clk = 1'b0;
        resetn = 1'b0;
        req = '0;
        uart_txd = 1'b1;
        test_pin = 1'b1;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        #1 check({uart_rxd, xcvr_txd, test_rxd, irq}, 4'he);
        rd(A_CTRL, d); check(d, 32'h0);
        rd(A_ST, d); check(d, 32'h0);
        rd(A_CMP, d); check(d, 32'hffff);
        rd(A_C2, d); check(d, ctrl2_val(1'b0, 1'b0, 4'h5));
        rd(8'h20, d); check(d, 32'h0);
        repeat (6) begin
            @(posedge ref_clk);
            v = $random(seed);
            uart_txd <= v;
            test_pin <= ~v;
            repeat (3) @(posedge ref_clk);
            #1 check({xcvr_txd, test_rxd}, {v, 1'b1});
        end
        // Test pin is already driven before test mode is entered
        wr(A_CTRL, 32'h0200);
        repeat (6) begin
            @(posedge ref_clk);
            v = $random(seed);
            test_pin <= v;
            uart_txd <= ~v;
            node.hold(v, 5);
            #1 check({xcvr_txd, test_rxd, uart_rxd}, {v, v, 1'b1});
        end
        node.hold(1'b1, 4);
        wr(A_CTRL, 32'h0);
        wr(A_C2, ctrl2_val(1'b1, 1'b0, 4'h5));
        wr(A_CTRL, 32'h0100);
        n = 10 + {$random(seed)} % 30;
        pulse(n);
        rd(A_ST, d); check({d[0], irq}, 2'b11);
        rd(A_BRK, d); check(d >= n - 2 && d <= n + 2, 1'b1);
        wr(A_ST, 32'h1f);
        wr(A_CTRL, 32'h1100);
        pulse(n);
        rd(A_ST, d); check({d[0], irq}, 2'b10);
        wr(A_ST, 32'h1f);
        wr(A_CTRL, 32'h1000);
        pulse(n);
        rd(A_ST, d); check(d[0], 1'b0);
        rd(A_BRK, d); check(d >= n - 2 && d <= n + 2, 1'b1);
        wr(A_CTRL, 32'h0c00);
        wr(A_BRK, 32'd20);
        wr(A_ST, 32'h1f);
        pulse(30);
        rd(A_ST, d); check({d[1], irq}, 2'b10);
        wr(A_CTRL, 32'h0400);
        @(posedge ref_clk);
        #1 check(irq, 1'b1);
        wr(A_CTRL, 32'h0800);
        wr(A_ST, 32'h1f);
        // Long enough for the 16-bit break timer to run out
        pulse(65560);
        rd(A_ST, d); check({d[2], irq}, 2'b11);
        wr(A_CTRL, 32'h0c00);
        @(posedge ref_clk);
        #1 check(irq, 1'b0);
        wr(A_ST, 32'h1f);
        wr(A_C2, ctrl2_val(1'b1, 1'b1, 4'h5));
        wr(A_CMP, 32'd15);
        node.hold(1'b0, 1);
        // Bus released once the sync compare flag interrupts, or after 60 cycles without it
        for (n = 0; n < 60 && !irq; n++) begin
            @(posedge ref_clk);
            #1;
        end
        node.hold(1'b1, 8);
        rd(A_ST, d); check({d[3], irq}, 2'b11);
        check(n < 60, 1'b1);
        wr(A_ST, 32'h1f);
        wr(A_C2, ctrl2_val(1'b0, 1'b0, 4'h5));
        wr(A_CMP, 32'hffff);
        wr(A_CTRL, 32'h0d80);
        node.hold(1'b0, 15);
        #1 check(uart_rxd, 1'b1);
        node.hold(1'b0, 15);
        #1 check(uart_rxd, 1'b1);
        node.hold(1'b1, 8);
        // Sync byte 0x55 with start and stop bits, sent lsb first
        for (int i = 0; i < 10; i++) begin
            node.hold(i[0] || i == 9, 8);
        end
        node.hold(1'b1, 8);
        rd(A_ST, d); check({d[4], d[0], irq}, 3'b110);
        rd(A_SYN, d);
        repeat (5) @(posedge ref_clk);
        rd(A_SYN, d2); check(d2, d);
        // Low control bits read back as zero
        wr(A_CTRL, 32'h1dff);
        rd(A_CTRL, d); check(d, 32'h1d80);
        check(irq, 1'b1);
        node.hold(1'b0, 6);
        #1 check(uart_rxd, 1'b0);
        node.hold(1'b1, 8);
        complete_run();
    end
endmodule
